// File: design/nib_increment_buffer.sv
// Increment register bank of a numerically controlled oscillator.
// Assumes an AXI4-Lite master on aclk and an oscillator clock sampled as a
// level input synchronous to aclk.
`timescale 1ns/10ps
module nib_increment_buffer
  import nib_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        oscillator_clock,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [19:0]      synth_increment
);

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic        aw_held_r, aw_held_nxt;
  logic [3:0]  aw_addr_r, aw_addr_nxt;
  logic        w_held_r, w_held_nxt;
  logic [7:0]  w_byte_r, w_byte_nxt;
  logic        w_lane_r, w_lane_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic [7:0]  low_r, low_nxt;
  logic [7:0]  high_r, high_nxt;
  logic [3:0]  upper_r, upper_nxt;
  logic        pend_r, pend_nxt;
  logic        osc_d_r, osc_d_nxt;
  logic [19:0] active_r, active_nxt;
  logic        do_write;

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_byte_nxt  = w_byte_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    low_nxt     = low_r;
    high_nxt    = high_r;
    upper_nxt   = upper_r;
    pend_nxt    = pend_r;
    active_nxt  = active_r;
    osc_d_nxt   = oscillator_clock;
    do_write    = aw_held_r && w_held_r && !bvalid_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    // Transfer on a falling oscillator edge; a new low write in the same
    // cycle re-arms the transfer so its value is not lost.
    if (pend_r && osc_d_r && !oscillator_clock) begin
      active_nxt = {upper_r, high_r, low_r};
      pend_nxt   = 1'b0;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = NIB_RESP_OKAY;
      unique case (aw_addr_r)
        NIB_OFF_LOW: begin
          if (w_lane_r) begin
            low_nxt  = w_byte_r;
            pend_nxt = 1'b1;
          end
        end
        NIB_OFF_HIGH: begin
          if (w_lane_r) high_nxt = w_byte_r;
        end
        NIB_OFF_UPPER: begin
          if (w_lane_r) upper_nxt = w_byte_r[NIB_UPPER_W-1:0];
        end
        NIB_OFF_ACTIVE: bresp_nxt = NIB_RESP_OKAY;
        default: bresp_nxt = NIB_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_held_r  <= 1'b0;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= NIB_RESP_OKAY;
      low_r     <= NIB_LOW_RST;
      high_r    <= NIB_HIGH_RST;
      upper_r   <= NIB_UPPER_RST;
      pend_r    <= 1'b0;
      osc_d_r   <= 1'b0;
      active_r  <= {NIB_UPPER_RST, NIB_HIGH_RST, NIB_LOW_RST};
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_byte_r  <= w_byte_nxt;
      w_lane_r  <= w_lane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      low_r     <= low_nxt;
      high_r    <= high_nxt;
      upper_r   <= upper_nxt;
      pend_r    <= pend_nxt;
      osc_d_r   <= osc_d_nxt;
      active_r  <= active_nxt;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    // Accept only on a real handshake: the ready flag is low for the first
    // cycle after reset, and a request seen then must still be waiting.
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = NIB_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case (s_axi_araddr)
        NIB_OFF_LOW:    rdata_nxt = {24'h00_0000, low_r};
        NIB_OFF_HIGH:   rdata_nxt = {24'h00_0000, high_r};
        NIB_OFF_UPPER:  rdata_nxt = {28'h000_0000, upper_r};
        NIB_OFF_ACTIVE: rdata_nxt = {12'h000, active_r};
        default:        rresp_nxt = NIB_RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= NIB_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // Ready flags are registers too: a channel is open while nothing is held.
  logic awready_r, wready_r, arready_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awready_r <= !aw_held_nxt && !(s_axi_awvalid && awready_r);
      wready_r  <= !w_held_nxt && !(s_axi_wvalid && wready_r);
      arready_r <= !rvalid_nxt;
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign synth_increment = active_r;

endmodule : nib_increment_buffer

// File: design/nib_pkg.sv
// Package for the increment register bank of the oscillator.
// Assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses.
package nib_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] NIB_OFF_LOW    = 4'h0;
  localparam logic [3:0] NIB_OFF_HIGH   = 4'h4;
  localparam logic [3:0] NIB_OFF_UPPER  = 4'h8;
  localparam logic [3:0] NIB_OFF_ACTIVE = 4'hc;
  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int         NIB_INC_W       = 20;
  localparam int         NIB_UPPER_W     = 4;
  localparam logic [7:0] NIB_LOW_RST     = 8'h01;
  localparam logic [7:0] NIB_HIGH_RST    = 8'h00;
  localparam logic [3:0] NIB_UPPER_RST   = 4'h0;
  localparam logic [1:0] NIB_RESP_OKAY   = 2'b00;
  localparam logic [1:0] NIB_RESP_SLVERR = 2'b10;
endpackage : nib_pkg

// File: verification/nib_props.sv
// Concurrent checks for the increment register bank.
// Assumes it is bound to nib_increment_buffer and sees only its ports.
`timescale 1ns/10ps
module nib_props
  import nib_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        oscillator_clock,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [19:0] synth_increment
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic up_r;
  always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) up_r <= s_axi_araddr == NIB_OFF_UPPER;
  // ****
  // Rules
  // ****
  rst_value_a: assert property ($rose(aresetn) |-> synth_increment == 20'h00001
    && !s_axi_rvalid && !s_axi_bvalid) else $error("reset state wrong");
  high_hold_a: assert property (oscillator_clock && $past(oscillator_clock)
    && $past(oscillator_clock, 2) |-> $stable(synth_increment)) else $error("load without fall");
  load_on_fall_a: assert property ($changed(synth_increment) |->
    (!$past(oscillator_clock) && $past(oscillator_clock, 2))
    || (!$past(oscillator_clock, 2) && $past(oscillator_clock, 3))) else $error("load off fall");
  upper_zero_a: assert property (s_axi_rvalid && up_r |-> s_axi_rdata[31:4] == '0)
    else $error("upper bits not zero");
  width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:20] == '0)
    else $error("read wider than increment");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($changed(synth_increment));
endmodule : nib_props

// File: verification/tb_nib_increment_buffer.sv
// Self-checking bench for the increment register bank.
// Assumes nib_props for protocol timing; oscillator falls are made by hand.
`timescale 1ns/10ps
module tb_nib_increment_buffer import nib_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0, oscillator_clock = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] synth_increment;
  logic [33:0] v;
  int          fail_count = 0, compares = 0, cycles = 0;
  nib_increment_buffer u_dut (.*);
  initial forever #25 aclk = ~aclk;
  // Cuts a hang short well past the fewer than a hundred cycles the run needs.
  always @(posedge aclk) if (++cycles == 5000) begin fail_count++; report_and_stop; end
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, want);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Handshakes are judged at the falling edge before each rising edge, where
  // the design's outputs are settled, and acted on at that rising edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      v = {s_axi_bresp, 32'h0};
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end while (!b_hs);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic ar_hs, r_hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      v = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end while (!r_hs);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic fall;
    @(posedge aclk);
    oscillator_clock <= 1'b1;
    repeat (3) @(posedge aclk);
    oscillator_clock <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : fall
  task automatic t_reset;
    chk(synth_increment, 34'h1);
    rd(NIB_OFF_LOW); chk(v, {NIB_RESP_OKAY, 32'h1});
    rd(NIB_OFF_HIGH); chk(v, {NIB_RESP_OKAY, 32'h0});
    rd(NIB_OFF_UPPER); chk(v, {NIB_RESP_OKAY, 32'h0});
  endtask : t_reset
  task automatic t_load;
    wr(NIB_OFF_UPPER, 32'hff);
    chk(v, {NIB_RESP_OKAY, 32'h0});
    wr(NIB_OFF_HIGH, 32'hab);
    chk(v, {NIB_RESP_OKAY, 32'h0});
    fall;
    chk(synth_increment, 34'h1);
    rd(NIB_OFF_UPPER); chk(v, {NIB_RESP_OKAY, 32'hf});
    wr(NIB_OFF_LOW, 32'hcd);
    chk(synth_increment, 34'h1);
    fall;
    chk(synth_increment, 34'hfabcd);
    rd(NIB_OFF_ACTIVE); chk(v, {NIB_RESP_OKAY, 32'hfabcd});
    rd(4'h2); chk(v, {NIB_RESP_SLVERR, 32'h0});
    wr(NIB_OFF_ACTIVE, 32'h0);
    chk(v, {NIB_RESP_OKAY, 32'h0});
    chk(synth_increment, 34'hfabcd);
    wr(4'h2, 32'h0);
    chk(v, {NIB_RESP_SLVERR, 32'h0});
    s_axi_wstrb <= 4'h0;
    wr(NIB_OFF_HIGH, 32'h55);
    s_axi_wstrb <= 4'hf;
    rd(NIB_OFF_HIGH); chk(v, {NIB_RESP_OKAY, 32'hab});
  endtask : t_load
  task automatic t_rereset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(synth_increment, 34'h1);
    rd(NIB_OFF_HIGH); chk(v, {NIB_RESP_OKAY, 32'h0});
  endtask : t_rereset
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_load;
    t_rereset;
    report_and_stop;
  end
endmodule : tb_nib_increment_buffer
bind nib_increment_buffer nib_props u_props (.*);
